// ---- verilog/ffiw_pkg.sv ----
// Package for the flash fault-inject and read wait-state control block.
// Assumes a single bus clock domain and an APB register port.
package ffiw_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Register map, byte addresses of 32-bit words.
    // ****************************************************************
    localparam logic [7:0] FLASH_CONFIG_IDX = 8'h04;
    localparam logic [7:0] FLASH_ERROR_IRQ_CONFIG_IDX = 8'h05;
    localparam logic [7:0] ERROR_STATUS_IDX = 8'h06;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h07;
    localparam logic [11:0] FLASH_CONFIG_ADDR = {2'h0, FLASH_CONFIG_IDX, 2'h0};
    localparam logic [11:0] FLASH_ERROR_IRQ_CONFIG_ADDR = {2'h0, FLASH_ERROR_IRQ_CONFIG_IDX, 2'h0};
    localparam logic [11:0] ERROR_STATUS_ADDR = {2'h0, ERROR_STATUS_IDX, 2'h0};
    localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int FSF_BIT = 0;
    localparam int FDF_BIT = 1;
    localparam int WSEL_LO = 2;
    localparam int ACK_BIT = 4;
    localparam int SFIE_BIT = 0;
    localparam int SFF_BIT = 0;
    localparam int DFF_BIT = 1;
    // ****************************************************************
    // Reset values and timing.
    // ****************************************************************
    localparam logic [1:0] WSEL_MAX = 2'h0;
    localparam logic [1:0] WSEL_NONE = 2'h3;
    localparam logic [1:0] WSEL_RST = WSEL_MAX;
    localparam logic [1:0] MASK_RST = 2'h3;
    localparam int CORE_MHZ = 100;
    localparam int BUS_MHZ = 50;
    localparam int MAX_WAIT_CYCLES = 1;
    typedef enum logic [1:0] {FFIW_IDLE, FFIW_WAIT, FFIW_DONE} ffiw_rd_e;
endpackage : ffiw_pkg

// ---- verilog/ffiw_wait_cnt.sv ----
// Read wait-state counter for one array read.
// Assumes start pulses only while idle; done is a one-cycle pulse.
module ffiw_wait_cnt
    import ffiw_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic start,
    input wire logic use_wait,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    logic busy_r;
    logic last;
    assign last = busy_r && (cnt_r == 2'(MAX_WAIT_CYCLES));
    assign done = (start && !use_wait) || last;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= 2'h0;
            busy_r <= 1'b0;
        end else if (start && use_wait) begin
            cnt_r <= 2'h1;
            busy_r <= 1'b1;
        end else if (last) begin
            busy_r <= 1'b0;
            cnt_r <= 2'h0;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule : ffiw_wait_cnt

// ---- verilog/ffiw_top.sv ----
// Flash read-path control: forced ECC faults, read wait-states, fault interrupt.
// Assumes an APB master on REF_CLK and a flash array on the same clock.
//
// Contract
// [RULE_01] With force double fault set, every array read sets the double fault flag.
// [RULE_02] With force double fault clear, only a real double fault sets that flag.
// [RULE_03] Force double fault is cleared only by software writing zero.
// [RULE_04] With force single fault set, each array read sets the single flag, interrupting if enabled; the code also needs irq_mask_r bit 0 set.
// [RULE_05] With force single fault clear, only a real single fault sets that flag.
// [RULE_06] Force single fault is cleared only by software writing zero.
// [RULE_07] Wait select 00 inserts the maximum wait cycles per read and 11 inserts none.
// [RULE_08] Codes 01 and 10 read back as written but time reads like 00.
// [RULE_09] Reset selects maximum waits, which is one wait cycle per read.
// [RULE_10] With the interrupt enable set, a set single fault flag requests an interrupt; the code also needs irq_mask_r bit 0 set.
// [RULE_11] With the interrupt enable clear, the single fault flag raises no interrupt.
// [RULE_12] All implemented bits of the error interrupt configuration register are read-write.
// [RULE_13] Writing the wait select clears the switch acknowledge until reads use the new value.
// [RULE_14] A wait select write during a flash command is ignored.
// [RULE_15] Software sees the switch acknowledge at one before changing frequency.
// [RULE_16] Forced faults apply only to array reads, never to register accesses.
module ffiw_top
    import ffiw_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ARRAY_RD_REQ,
    output logic ARRAY_RD_ACK,
    input wire logic ECC_SINGLE_FAULT,
    input wire logic ECC_DOUBLE_FAULT,
    input wire logic COMMAND_COMPLETE_FLAG,
    output logic [1:0] READ_WAIT_SELECT,
    output logic DOUBLE_FAULT_FLAG,
    output logic SINGLE_FAULT_FLAG,
    output logic IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic force_single_fault_r;
    logic force_double_fault_r;
    logic [1:0] read_wait_select_r;
    logic [1:0] active_wsel_r;
    logic wait_switch_ack_r;
    logic single_fault_irq_enable_r;
    logic single_fault_flag_r;
    logic double_fault_flag_r;
    logic [1:0] irq_mask_r;
    logic [31:0] prdata_r;
    ffiw_rd_e rd_state_r;
    ffiw_rd_e rd_state_nxt;
    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire acc = PSEL && PENABLE;
    wire wr = acc && PWRITE;
    wire rd_setup = PSEL && !PENABLE && !PWRITE;
    wire hit_cfg = (PADDR == FLASH_CONFIG_ADDR);
    wire hit_ecfg = (PADDR == FLASH_ERROR_IRQ_CONFIG_ADDR);
    wire hit_stat = (PADDR == ERROR_STATUS_ADDR);
    wire hit_mask = (PADDR == IRQ_MASK_ADDR);
    wire mapped = hit_cfg || hit_ecfg || hit_stat || hit_mask;
    wire wr_cfg = wr && hit_cfg;
    // A busy command sequencer freezes the wait select. [RULE_14]
    wire wsel_wr_ok = wr_cfg && COMMAND_COMPLETE_FLAG;
    wire [1:0] wsel_new = PWDATA[WSEL_LO+1:WSEL_LO];
    assign PREADY = 1'b1;
    assign PSLVERR = acc && !mapped;
    assign PRDATA = prdata_r;
    // ****************************************************************
    // Array read sequencing.
    // ****************************************************************
    // Only codes 11 skip waiting; reserved codes time like 00. [RULE_07] [RULE_08]
    wire use_wait = (active_wsel_r != WSEL_NONE);
    wire rd_start = (rd_state_r == FFIW_IDLE) && ARRAY_RD_REQ;
    wire rd_done;
    ffiw_wait_cnt u_wait (
        .REF_CLK(REF_CLK),
        .RST_N(RST_N),
        .start(rd_start),
        .use_wait(use_wait),
        .done(rd_done)
    );
    always_comb begin
        rd_state_nxt = rd_state_r;
        case (rd_state_r)
            FFIW_IDLE: begin
                if (rd_start && !rd_done) rd_state_nxt = FFIW_WAIT;
            end
            FFIW_WAIT: begin
                if (rd_done) rd_state_nxt = FFIW_IDLE;
            end
            default: rd_state_nxt = FFIW_IDLE;
        endcase
    end
    assign ARRAY_RD_ACK = rd_done;
    // Faults are sampled only when an array read finishes. [RULE_16]
    wire set_sf = rd_done && (force_single_fault_r || ECC_SINGLE_FAULT); // [RULE_04] [RULE_05]
    wire set_df = rd_done && (force_double_fault_r || ECC_DOUBLE_FAULT); // [RULE_01] [RULE_02]
    wire clr_sf = wr && hit_stat && PWDATA[SFF_BIT];
    wire clr_df = wr && hit_stat && PWDATA[DFF_BIT];
    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_state_r <= FFIW_IDLE;
            force_single_fault_r <= 1'b0;
            force_double_fault_r <= 1'b0;
            read_wait_select_r <= WSEL_RST; // [RULE_09]
            active_wsel_r <= WSEL_RST;
            wait_switch_ack_r <= 1'b1;
            single_fault_irq_enable_r <= 1'b0;
            single_fault_flag_r <= 1'b0;
            double_fault_flag_r <= 1'b0;
            irq_mask_r <= MASK_RST;
        end else begin
            rd_state_r <= rd_state_nxt;
            if (wr_cfg) begin
                force_single_fault_r <= PWDATA[FSF_BIT]; // [RULE_06]
                force_double_fault_r <= PWDATA[FDF_BIT]; // [RULE_03]
            end
            // The new setting is taken up only between reads, so no read mixes timings.
            if (wsel_wr_ok) begin
                read_wait_select_r <= wsel_new;
                wait_switch_ack_r <= 1'b0; // [RULE_13]
            end else if (!wait_switch_ack_r && rd_state_r == FFIW_IDLE && !ARRAY_RD_REQ) begin
                active_wsel_r <= read_wait_select_r;
                wait_switch_ack_r <= 1'b1; // [RULE_13]
            end
            if (wr && hit_ecfg) single_fault_irq_enable_r <= PWDATA[SFIE_BIT]; // [RULE_12]
            if (wr && hit_mask) irq_mask_r <= PWDATA[1:0];
            // Set beats clear in the same cycle.
            if (set_sf) single_fault_flag_r <= 1'b1;
            else if (clr_sf) single_fault_flag_r <= 1'b0;
            if (set_df) double_fault_flag_r <= 1'b1;
            else if (clr_df) double_fault_flag_r <= 1'b0;
        end
    end
    // ****************************************************************
    // Read data.
    // ****************************************************************
    wire [31:0] cfg_rd = {27'h0, wait_switch_ack_r, read_wait_select_r,
                          force_double_fault_r, force_single_fault_r};
    wire [31:0] rd_mux = hit_cfg ? cfg_rd :
                         hit_ecfg ? {31'h0, single_fault_irq_enable_r} :
                         hit_stat ? {30'h0, double_fault_flag_r, single_fault_flag_r} :
                         hit_mask ? {30'h0, irq_mask_r} : 32'h0;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) prdata_r <= 32'h0;
        else if (rd_setup) prdata_r <= rd_mux;
    end
    // ****************************************************************
    // Outputs and interrupt.
    // ****************************************************************
    assign READ_WAIT_SELECT = read_wait_select_r;
    assign DOUBLE_FAULT_FLAG = double_fault_flag_r;
    assign SINGLE_FAULT_FLAG = single_fault_flag_r;
    // Double faults have no enable of their own, so only the mask gates them.
    assign IRQ = (single_fault_flag_r && single_fault_irq_enable_r && irq_mask_r[SFF_BIT])
                 || (double_fault_flag_r && irq_mask_r[DFF_BIT]); // [RULE_10] [RULE_11]
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_force_df;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_done && force_double_fault_r) |=> double_fault_flag_r;
    endproperty
    a_force_df: assert property (p_force_df) else $error("forced double fault lost"); // [RULE_01]
    property p_real_df;
        @(posedge REF_CLK) disable iff (!RST_N)
        ($rose(double_fault_flag_r)) |-> $past(rd_done && (force_double_fault_r || ECC_DOUBLE_FAULT));
    endproperty
    a_real_df: assert property (p_real_df) else $error("double flag set without cause"); // [RULE_02]
    property p_fdf_hold;
        @(posedge REF_CLK) disable iff (!RST_N)
        $fell(force_double_fault_r) |-> $past(wr_cfg && !PWDATA[FDF_BIT]);
    endproperty
    a_fdf_hold: assert property (p_fdf_hold) else $error("force double cleared wrongly"); // [RULE_03]
    property p_force_sf;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_done && force_single_fault_r && single_fault_irq_enable_r && irq_mask_r[0]) |=> IRQ;
    endproperty
    a_force_sf: assert property (p_force_sf) else $error("forced single no irq"); // [RULE_04]
    property p_real_sf;
        @(posedge REF_CLK) disable iff (!RST_N)
        ($rose(single_fault_flag_r)) |-> $past(rd_done && (force_single_fault_r || ECC_SINGLE_FAULT));
    endproperty
    a_real_sf: assert property (p_real_sf) else $error("single flag set without cause"); // [RULE_05]
    property p_fsf_hold;
        @(posedge REF_CLK) disable iff (!RST_N)
        $fell(force_single_fault_r) |-> $past(wr_cfg && !PWDATA[FSF_BIT]);
    endproperty
    a_fsf_hold: assert property (p_fsf_hold) else $error("force single cleared wrongly"); // [RULE_06]
    property p_wait;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_start && use_wait) |-> !ARRAY_RD_ACK ##1 ARRAY_RD_ACK;
    endproperty
    a_wait: assert property (p_wait) else $error("wait cycle count wrong"); // [RULE_07] [RULE_09]
    property p_nowait;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_start && active_wsel_r == WSEL_NONE) |-> ARRAY_RD_ACK;
    endproperty
    a_nowait: assert property (p_nowait) else $error("no-wait read delayed"); // [RULE_07] [RULE_08]
    property p_no_irq;
        @(posedge REF_CLK) disable iff (!RST_N)
        (!single_fault_irq_enable_r && !double_fault_flag_r) |-> !IRQ;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq while disabled"); // [RULE_11]
    property p_busy_wr;
        @(posedge REF_CLK) disable iff (!RST_N)
        (wr_cfg && !COMMAND_COMPLETE_FLAG) |=> $stable(read_wait_select_r);
    endproperty
    a_busy_wr: assert property (p_busy_wr) else $error("wait select changed while busy"); // [RULE_14]
    property p_ack;
        @(posedge REF_CLK) disable iff (!RST_N)
        wsel_wr_ok |=> !wait_switch_ack_r;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not cleared"); // [RULE_13]
    property p_irq_on;
        @(posedge REF_CLK) disable iff (!RST_N)
        (single_fault_flag_r && single_fault_irq_enable_r && irq_mask_r[SFF_BIT]) |-> IRQ;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("enabled single flag no irq"); // [RULE_10]
    property p_irq_off;
        @(posedge REF_CLK) disable iff (!RST_N)
        (!single_fault_irq_enable_r && !irq_mask_r[DFF_BIT]) |-> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with sources off"); // [RULE_11]
    property p_force_sff;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_done && force_single_fault_r) |=> single_fault_flag_r;
    endproperty
    a_force_sff: assert property (p_force_sff) else $error("forced single flag lost"); // [RULE_04]
    property p_reg_sf;
        @(posedge REF_CLK) disable iff (!RST_N)
        (!rd_done && !single_fault_flag_r) |=> !single_fault_flag_r;
    endproperty
    a_reg_sf: assert property (p_reg_sf) else $error("single flag set off a read"); // [RULE_16]
    property p_reg_df;
        @(posedge REF_CLK) disable iff (!RST_N)
        (!rd_done && !double_fault_flag_r) |=> !double_fault_flag_r;
    endproperty
    a_reg_df: assert property (p_reg_df) else $error("double flag set off a read"); // [RULE_16]
    property p_fdf_keep;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_done && force_double_fault_r && !wr_cfg) |=> force_double_fault_r;
    endproperty
    a_fdf_keep: assert property (p_fdf_keep) else $error("read cleared force double"); // [RULE_03]
    property p_fsf_keep;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_done && force_single_fault_r && !wr_cfg) |=> force_single_fault_r;
    endproperty
    a_fsf_keep: assert property (p_fsf_keep) else $error("read cleared force single"); // [RULE_06]
    property p_fdf_set;
        @(posedge REF_CLK) disable iff (!RST_N)
        (wr_cfg && PWDATA[FDF_BIT]) |=> force_double_fault_r;
    endproperty
    a_fdf_set: assert property (p_fdf_set) else $error("force double not set"); // [RULE_01]
    property p_fsf_set;
        @(posedge REF_CLK) disable iff (!RST_N)
        (wr_cfg && PWDATA[FSF_BIT]) |=> force_single_fault_r;
    endproperty
    a_fsf_set: assert property (p_fsf_set) else $error("force single not set"); // [RULE_04]
    property p_ack_match;
        @(posedge REF_CLK) disable iff (!RST_N)
        wait_switch_ack_r |-> (active_wsel_r == read_wait_select_r);
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("ack with stale timing"); // [RULE_13]
    property p_no_switch;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_state_r != FFIW_IDLE || ARRAY_RD_REQ) |=> $stable(active_wsel_r);
    endproperty
    a_no_switch: assert property (p_no_switch) else $error("timing switched mid read"); // [RULE_13]
    property p_busy_ack;
        @(posedge REF_CLK) disable iff (!RST_N)
        (wr_cfg && !COMMAND_COMPLETE_FLAG && wait_switch_ack_r) |=> wait_switch_ack_r;
    endproperty
    a_busy_ack: assert property (p_busy_ack) else $error("busy write started a switch"); // [RULE_14]
    property p_wsel_rw;
        @(posedge REF_CLK) disable iff (!RST_N)
        wsel_wr_ok |=> (read_wait_select_r == $past(wsel_new));
    endproperty
    a_wsel_rw: assert property (p_wsel_rw) else $error("wait select not stored"); // [RULE_08]
    property p_ecfg_rw;
        @(posedge REF_CLK) disable iff (!RST_N)
        (wr && hit_ecfg) |=> (single_fault_irq_enable_r == $past(PWDATA[SFIE_BIT]));
    endproperty
    a_ecfg_rw: assert property (p_ecfg_rw) else $error("irq enable not stored"); // [RULE_12]
    property p_rsv_wait;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_start && (active_wsel_r[0] != active_wsel_r[1])) |-> !ARRAY_RD_ACK ##1 ARRAY_RD_ACK;
    endproperty
    a_rsv_wait: assert property (p_rsv_wait) else $error("reserved code timing wrong"); // [RULE_08]
    property p_max_wait;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rd_start && active_wsel_r == WSEL_MAX) |-> !ARRAY_RD_ACK ##1 ARRAY_RD_ACK;
    endproperty
    a_max_wait: assert property (p_max_wait) else $error("maximum wait timing wrong"); // [RULE_09]
endmodule : ffiw_top

// ---- testbench/ffiw_flash_model.sv ----
// Flash array ECC model: reports faults in the read-complete cycle.
// Assumes faults are sampled only while the read-complete pulse is high.
module ffiw_flash_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rd_ack,
    input wire logic inj_single,
    input wire logic inj_double,
    output logic ecc_single,
    output logic ecc_double
);
    timeunit 1ns;
    timeprecision 1ns;
    logic junk_r;
    // Off the read cycle the lines toggle, so a stale fault never passes for a real one.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            junk_r <= 1'b0;
        end else begin
            junk_r <= ~junk_r;
        end
    end
    assign ecc_single = rd_ack ? inj_single : junk_r;
    assign ecc_double = rd_ack ? inj_double : ~junk_r;
endmodule : ffiw_flash_model

// ---- testbench/testbench.sv ----
// Self-checking bench for ffiw_top: APB master, array reads, random faults.
// Assumes zero-wait APB answers and fault flags that land one cycle after ACK.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ffiw_pkg::*;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_req = 1'b0, cmd_done = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic [31:0] seed = 32'ha021;
    logic pready, pslverr, sl_v, rd_ack, ecc_s, ecc_d, inj_s = 1'b0, inj_d = 1'b0;
    logic [1:0] wsel_o;
    logic df_o, sf_o, irq_o;
    int err_count = 0, num_checks = 0, lat;
    always #20 REF_CLK = ~REF_CLK;
    ffiw_top dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ARRAY_RD_REQ(rd_req), .ARRAY_RD_ACK(rd_ack),
        .ECC_SINGLE_FAULT(ecc_s), .ECC_DOUBLE_FAULT(ecc_d), .COMMAND_COMPLETE_FLAG(cmd_done),
        .READ_WAIT_SELECT(wsel_o), .DOUBLE_FAULT_FLAG(df_o), .SINGLE_FAULT_FLAG(sf_o),
        .IRQ(irq_o));
    ffiw_flash_model model_u (.ref_clk(REF_CLK), .rst_n(RST_N), .rd_ack(rd_ack),
        .inj_single(inj_s), .inj_double(inj_d), .ecc_single(ecc_s), .ecc_double(ecc_d));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic int exp_lat(input logic [1:0] w);
        return (w == WSEL_NONE) ? 0 : MAX_WAIT_CYCLES;
    endfunction : exp_lat
    function automatic logic exp_irq(input logic s, d, e, input logic [1:0] m);
        return (s & e & m[0]) | (d & m[1]);
    endfunction : exp_irq
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic hang();
        err_count++;
        $display("BAD t=%0t wait ran out", $time);
        print_verdict();
    endtask : hang
    // The idle cycle at the start keeps two transfers from driving psel in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge REF_CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge REF_CLK);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge REF_CLK);
            if (pready === 1'b1) break;
        end
        if (n == 16) hang();
        rd_v = prdata;
        sl_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_ack();
        int n;
        for (n = 0; n < 8; n++) begin
            apb(1'b0, FLASH_CONFIG_ADDR, 32'h0);
            if (rd_v[ACK_BIT] === 1'b1) break;
        end
        if (n == 8) hang();
    endtask : wait_ack
    task automatic arr_read();
        @(posedge REF_CLK);
        rd_req <= 1'b1;
        for (lat = 0; lat < 8; lat++) begin
            @(posedge REF_CLK);
            if (rd_ack === 1'b1) break;
        end
        if (lat == 8) hang();
        rd_req <= 1'b0;
        @(posedge REF_CLK);
    endtask : arr_read
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        int i;
        logic [1:0] w, m;
        logic fs, fd, es, ed, ie;
        repeat (3) @(posedge REF_CLK);
        RST_N <= 1'b1;
        apb(1'b0, FLASH_CONFIG_ADDR, 32'h0);
        check(rd_v & 32'h0000000f, 32'h0);
        check(wsel_o, WSEL_RST);
        apb(1'b0, FLASH_ERROR_IRQ_CONFIG_ADDR, 32'h0);
        check(rd_v, 32'h0);
        apb(1'b0, IRQ_MASK_ADDR, 32'h0);
        check(rd_v, {30'h0, MASK_RST});
        $display("reset values done");
        for (i = 0; i < 4; i++) begin
            w = i[1:0];
            apb(1'b1, FLASH_CONFIG_ADDR, {28'h0, w, 2'h0});
            wait_ack();
            check(rd_v[3:2], w);
            check(wsel_o, w);
            arr_read();
            check(lat, exp_lat(w));
        end
        $display("wait codes done");
        cmd_done <= 1'b0;
        apb(1'b1, FLASH_CONFIG_ADDR, {28'h0, WSEL_MAX, 2'h0});
        apb(1'b0, FLASH_CONFIG_ADDR, 32'h0);
        check(rd_v[3:2], WSEL_NONE);
        arr_read();
        check(lat, 0);
        cmd_done <= 1'b1;
        apb(1'b1, 12'h3fc, 32'hffffffff);
        check(sl_v, 1'b1);
        $display("busy write and unmapped done");
        for (i = 0; i < 24; i++) begin
            seed = xs(seed);
            {fs, fd, es, ed, ie, m} = seed[6:0];
            apb(1'b1, FLASH_CONFIG_ADDR, {28'h0, WSEL_NONE, fd, fs});
            apb(1'b1, FLASH_ERROR_IRQ_CONFIG_ADDR, {31'h0, ie});
            apb(1'b1, IRQ_MASK_ADDR, {30'h0, m});
            apb(1'b1, ERROR_STATUS_ADDR, 32'h3);
            apb(1'b0, ERROR_STATUS_ADDR, 32'h0);
            check(rd_v, 32'h0);
            inj_s <= es;
            inj_d <= ed;
            arr_read();
            check(sf_o, fs | es);
            check(df_o, fd | ed);
            check(irq_o, exp_irq(fs | es, fd | ed, ie, m));
            apb(1'b0, ERROR_STATUS_ADDR, 32'h0);
            check(rd_v, {30'h0, fd | ed, fs | es});
            apb(1'b0, FLASH_CONFIG_ADDR, 32'h0);
            check(rd_v[1:0], {fd, fs});
            apb(1'b0, FLASH_ERROR_IRQ_CONFIG_ADDR, 32'h0);
            check(rd_v, {31'h0, ie});
        end
        $display("random faults done");
        inj_s <= 1'b0;
        inj_d <= 1'b0;
        RST_N <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        RST_N <= 1'b1;
        apb(1'b0, FLASH_CONFIG_ADDR, 32'h0);
        check(rd_v[3:0], {WSEL_RST, 2'h0});
        check(wsel_o, WSEL_RST);
        arr_read();
        check(lat, MAX_WAIT_CYCLES);
        check({sf_o, df_o}, 2'h0);
        $display("mid-run reset done");
        print_verdict();
    end
endmodule : testbench
